/* logic/fguard_pkg.sv */
// Constants shared by the flash mode write guard and its helpers.
// Assumes an 8-bit peripheral store/read port and a 16-bit address space.
// Contract
// - After the key: value, inverse, value; the first two stores are ignored.
// - Mode register changes only on the third store of a clean sequence.
// - One unlock allows one update; each change needs a fresh key.
// - A violation leaves the mode register unchanged and sets error bit 0.
// - The error flag is sticky; cleared by writing 0 or by reset.
// - Reset clears the protect status register to 00H.
// - The key register is undefined after reset; its contents never unlock.
// - A mode register write not preceded by a key A5H store raises an error.
// - Any of the three stores after the key to another register errs; a repeated A5H key store before the first value does not.
// - Second store not the exact inverse of the first raises an error.
// - Third store differing from the first store raises an error.
// - Flash address from CPU when upper mode bit is 0, else firmware.
// - In on-board programming mode both mode select bits are ignored.
// - Boot swap exchanges the two 4 KB boot clusters.
// - Boot swap takes effect only at the next reset and start.
// - Debug flag and security ID swap with their 1084H/1085H copies.
// - Write or erase permitted only with inhibit 0 and pin status 1.
// - Mode 00 normal, 01 firmware call at 8100H, 11 firmware fetch, 10 prohibited.
// - Mode register resets to 08H in user mode, 0CH in on-board mode.
// - Bits 7:4 read zero, bit 3 inhibit, bit 2 pin copy, bits 1:0 mode.
package fguard_pkg;
    localparam logic [15:0] MODE_CTRL_ADDR = 16'hffc4;
    localparam logic [15:0] UNLOCK_KEY_ADDR = 16'hffc0;
    localparam logic [15:0] PROT_STATUS_ADDR = 16'hffc2;
    localparam logic [7:0] UNLOCK_KEY_VALUE = 8'ha5;
    localparam logic [7:0] PROT_STATUS_RESET = 8'h00;
    localparam logic [7:0] MODE_CTRL_USER_RESET = 8'h08;
    localparam int INHIBIT_BIT = 3;
    localparam int PIN_BIT = 2;
    localparam int ERROR_BIT = 0;
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_FW_CALL = 2'h1;
    localparam logic [1:0] MODE_PROHIBITED = 2'h2;
    localparam logic [1:0] MODE_FW_FETCH = 2'h3;
    localparam logic [15:0] FW_CALL_ENTRY = 16'h8100;
    localparam int CLUSTER_BIT = 12;
    localparam logic [2:0] BOOT_CLUSTER_TOP = 3'h0;
    typedef enum {S_IDLE, S_KEY, S_VALUE, S_INVERSE} track_t;
endpackage : fguard_pkg

/* logic/remap_if.sv */
// Carries the flash address request and the remapped address.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
interface remap_if;
    logic [15:0] cpu_addr;
    logic [15:0] fw_addr;
    logic use_fw;
    logic swap;
    logic [15:0] flash_addr;
    modport ctrl (output cpu_addr, output fw_addr, output use_fw, output swap, input flash_addr);
    modport map (input cpu_addr, input fw_addr, input use_fw, input swap, output flash_addr);
endinterface : remap_if

/* logic/pin_sync.sv */
// Two-stage synchroniser for pins from outside the clock domain.
// Assumes the pins are quasi-static levels.
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 3
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic en,
    // Pins in, synchronised levels out
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] level
);
    logic [WIDTH-1:0] meta;

    if (WIDTH < 1) begin : g_width_check
        $error("pin_sync needs WIDTH of at least 1");
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= '0;
            level <= '0;
        end else if (en) begin
            meta <= pin;
            level <= meta;
        end
    end
endmodule : pin_sync

/* logic/addr_remap.sv */
// Selects the flash array address source and applies the boot cluster swap.
// Assumes swap is already frozen from the last reset.
`timescale 1ns/1ps
module addr_remap (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic en,
    // Address request
    remap_if.map rm
);
    logic [15:0] sel;
    logic in_boot;
    localparam int CLUSTER_BIT = fguard_pkg::CLUSTER_BIT;

    always_comb begin
        sel = rm.use_fw ? rm.fw_addr : rm.cpu_addr;
        in_boot = sel[15:CLUSTER_BIT+1] == fguard_pkg::BOOT_CLUSTER_TOP;
    end

    // Flipping the cluster bit swaps 0000H-0FFFH with 1000H-1FFFH, the ID area included.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rm.flash_addr <= 16'h0000;
        end else if (en) begin
            rm.flash_addr <= sel ^ ((rm.swap && in_boot) ? 16'h1000 : 16'h0000);
        end
    end

    a_swap_flip: assert property (@(posedge clk) disable iff (rst)
        en && rm.swap && in_boot |=>
        rm.flash_addr[CLUSTER_BIT] != $past(sel[CLUSTER_BIT]) && rm.flash_addr[11:0] == $past(sel[11:0]))
        else $error("boot cluster address not swapped");
endmodule : addr_remap

/* logic/flash_mode_write_guard.sv */
// Top of the flash mode write guard: protected mode register, unlock tracker,
// protect status, write permit and boot swap address mapping.
// Assumes single-cycle peripheral stores and reads from the CPU on MCLK.
`timescale 1ns/1ps
module flash_mode_write_guard (
    // Clock, reset, enable
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic CLK_EN,
    // Peripheral store and read port
    input wire logic SFR_WR,
    input wire logic SFR_RD,
    input wire logic [15:0] SFR_ADDR,
    input wire logic [7:0] SFR_WDATA,
    output logic [7:0] SFR_RDATA,
    // Firmware privilege, needed to select firmware fetch mode
    input wire logic FW_PRIV,
    // Pins
    input wire logic FLASH_MODE_PIN,
    input wire logic ONBOARD_MODE,
    input wire logic BOOT_FLAG,
    // Flash address path
    input wire logic [15:0] CPU_ADDR,
    input wire logic [15:0] FW_ADDR,
    output logic [15:0] FLASH_ADDR,
    // Flash control status
    output logic FLASH_WR_PERMIT,
    output logic FW_CALL_EN,
    output logic FW_ROM_FETCH,
    output logic BOOT_SWAPPED,
    output logic PROT_ERROR
);
    fguard_pkg::track_t state;
    logic [7:0] first_value;
    logic [7:0] key_store;
    logic inhibit;
    logic [1:0] mode;
    logic error_flag;
    logic onboard;
    logic swap;
    logic [1:0] strap_age;
    logic strap_taken;
    logic pin_level;
    logic onboard_level;
    logic boot_level;
    logic store;
    logic to_key;
    logic to_mode;
    logic to_status;
    logic violation;
    logic update;
    logic [1:0] mode_eff;
    logic [7:0] mode_view;
    logic [1:0] next_mode;
    remap_if rm ();

    pin_sync #(
        .WIDTH(3)
    ) u_sync (
        .clk(MCLK),
        .rst(SYS_RST),
        .en(CLK_EN),
        .pin({FLASH_MODE_PIN, ONBOARD_MODE, BOOT_FLAG}),
        .level({pin_level, onboard_level, boot_level})
    );

    always_comb begin
        store = CLK_EN && SFR_WR;
        to_key = SFR_ADDR == fguard_pkg::UNLOCK_KEY_ADDR;
        to_mode = SFR_ADDR == fguard_pkg::MODE_CTRL_ADDR;
        to_status = SFR_ADDR == fguard_pkg::PROT_STATUS_ADDR;
    end

    // Classify each store against the tracker position.
    always_comb begin
        violation = 1'b0;
        update = 1'b0;
        if (store) begin
            case (state)
                fguard_pkg::S_IDLE: begin
                    violation = (to_key && SFR_WDATA != fguard_pkg::UNLOCK_KEY_VALUE) || to_mode;
                end
                fguard_pkg::S_KEY: begin
                    if (to_key) begin
                        violation = SFR_WDATA != fguard_pkg::UNLOCK_KEY_VALUE;
                    end else begin
                        violation = !to_mode;
                    end
                end
                fguard_pkg::S_VALUE: begin
                    violation = !to_mode || SFR_WDATA != ~first_value;
                end
                fguard_pkg::S_INVERSE: begin
                    violation = !to_mode || SFR_WDATA != first_value;
                    update = !violation;
                end
                default: begin
                    violation = 1'b0;
                end
            endcase
        end
    end

    // Unlock sequence tracker.
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state <= fguard_pkg::S_IDLE;
        end else if (store) begin
            if (violation || update) begin
                state <= fguard_pkg::S_IDLE;
            end else begin
                case (state)
                    fguard_pkg::S_IDLE: begin
                        if (to_key) begin
                            state <= fguard_pkg::S_KEY;
                        end
                    end
                    fguard_pkg::S_KEY: begin
                        if (to_mode) begin
                            state <= fguard_pkg::S_VALUE;
                        end
                    end
                    fguard_pkg::S_VALUE: begin
                        state <= fguard_pkg::S_INVERSE;
                    end
                    default: begin
                        state <= fguard_pkg::S_IDLE;
                    end
                endcase
            end
        end
    end

    // The first store of the sequence is remembered for the later comparisons.
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            first_value <= 8'h00;
        end else if (store && state == fguard_pkg::S_KEY && to_mode) begin
            first_value <= SFR_WDATA;
        end
    end

    // Key contents are kept only for read-back and never unlock anything.
    always_ff @(posedge MCLK) begin
        if (store && to_key) begin
            key_store <= SFR_WDATA;
        end
    end

    // Mode bits: prohibited 10 is refused, 11 needs firmware privilege.
    always_comb begin
        next_mode = SFR_WDATA[1:0];
        if (next_mode == fguard_pkg::MODE_PROHIBITED) begin
            next_mode = mode;
        end else if (next_mode == fguard_pkg::MODE_FW_FETCH && !FW_PRIV) begin
            next_mode = mode;
        end
    end

    // Protected mode register; only a clean third store reaches it.
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            inhibit <= fguard_pkg::MODE_CTRL_USER_RESET[fguard_pkg::INHIBIT_BIT];
            mode <= fguard_pkg::MODE_NORMAL;
        end else if (update) begin
            inhibit <= SFR_WDATA[fguard_pkg::INHIBIT_BIT];
            mode <= next_mode;
        end
    end

    // Sticky error flag; a new violation wins over a clear in the same cycle.
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            error_flag <= fguard_pkg::PROT_STATUS_RESET[fguard_pkg::ERROR_BIT];
        end else if (violation) begin
            error_flag <= 1'b1;
        end else if (store && to_status && !SFR_WDATA[fguard_pkg::ERROR_BIT]) begin
            error_flag <= 1'b0;
        end
    end

    // Straps are caught once the synchroniser holds settled levels, so a new boot flag waits for the next reset.
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            strap_age <= 2'h0;
            strap_taken <= 1'b0;
            onboard <= 1'b0;
            swap <= 1'b0;
        end else if (CLK_EN) begin
            strap_age <= {strap_age[0], 1'b1};
            if (strap_age[1] && !strap_taken) begin
                strap_taken <= 1'b1;
                onboard <= onboard_level;
                swap <= boot_level;
            end
        end
    end

    always_comb begin
        mode_eff = onboard ? fguard_pkg::MODE_NORMAL : mode;
        mode_view = 8'h00;
        mode_view[fguard_pkg::INHIBIT_BIT] = inhibit;
        mode_view[fguard_pkg::PIN_BIT] = pin_level;
        mode_view[1:0] = mode;
    end

    // Register reads; unmapped addresses return zero.
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            SFR_RDATA <= 8'h00;
        end else if (CLK_EN && SFR_RD) begin
            if (SFR_ADDR == fguard_pkg::MODE_CTRL_ADDR) begin
                SFR_RDATA <= mode_view;
            end else if (SFR_ADDR == fguard_pkg::PROT_STATUS_ADDR) begin
                SFR_RDATA <= {7'h00, error_flag};
            end else if (SFR_ADDR == fguard_pkg::UNLOCK_KEY_ADDR) begin
                SFR_RDATA <= key_store;
            end else begin
                SFR_RDATA <= 8'h00;
            end
        end
    end

    // Status outputs.
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            FLASH_WR_PERMIT <= 1'b0;
            FW_CALL_EN <= 1'b0;
            FW_ROM_FETCH <= 1'b0;
        end else if (CLK_EN) begin
            FLASH_WR_PERMIT <= !inhibit && pin_level;
            FW_CALL_EN <= mode_eff == fguard_pkg::MODE_FW_CALL;
            FW_ROM_FETCH <= mode_eff == fguard_pkg::MODE_FW_FETCH;
        end
    end

    assign BOOT_SWAPPED = swap;
    assign PROT_ERROR = error_flag;
    assign rm.cpu_addr = CPU_ADDR;
    assign rm.fw_addr = FW_ADDR;
    assign rm.use_fw = mode_eff[1];
    assign rm.swap = swap;
    assign FLASH_ADDR = rm.flash_addr;

    addr_remap u_remap (
        .clk(MCLK),
        .rst(SYS_RST),
        .en(CLK_EN),
        .rm(rm.map)
    );

    a_update_needs_seq: assert property (@(posedge MCLK) disable iff (SYS_RST)
        $past(CLK_EN) && ($changed(inhibit) || $changed(mode)) |->
        $past(state) == fguard_pkg::S_INVERSE && $past(store) && $past(to_mode))
        else $error("mode register changed outside a completed sequence");

    a_early_stores_ignored: assert property (@(posedge MCLK) disable iff (SYS_RST)
        store && to_mode && (state == fguard_pkg::S_KEY || state == fguard_pkg::S_VALUE) |=>
        $stable(inhibit) && $stable(mode))
        else $error("first or second store changed the mode register");

    a_bad_key_errs: assert property (@(posedge MCLK) disable iff (SYS_RST)
        store && to_key && SFR_WDATA != fguard_pkg::UNLOCK_KEY_VALUE |=>
        error_flag && state == fguard_pkg::S_IDLE)
        else $error("bad key write did not raise an error");

    a_inverse_check: assert property (@(posedge MCLK) disable iff (SYS_RST)
        store && state == fguard_pkg::S_VALUE && to_mode && SFR_WDATA != ~first_value |=>
        error_flag ##0 $stable(mode))
        else $error("wrong inverse not flagged");

    a_third_check: assert property (@(posedge MCLK) disable iff (SYS_RST)
        store && state == fguard_pkg::S_INVERSE && to_mode && SFR_WDATA != first_value |=>
        error_flag && $stable(inhibit))
        else $error("wrong third store not flagged");

    a_foreign_store_errs: assert property (@(posedge MCLK) disable iff (SYS_RST)
        store && state != fguard_pkg::S_IDLE && !to_mode && !to_key |=> error_flag)
        else $error("foreign store inside sequence not flagged");

    a_error_sticky: assert property (@(posedge MCLK) disable iff (SYS_RST)
        error_flag && !(store && to_status && !SFR_WDATA[0]) |=> error_flag)
        else $error("error flag dropped without a clear");

    a_one_update: assert property (@(posedge MCLK) disable iff (SYS_RST)
        update |=> state == fguard_pkg::S_IDLE ##1 !update)
        else $error("unlock allowed more than one update");

    a_idle_unrelated: assert property (@(posedge MCLK) disable iff (SYS_RST)
        store && state == fguard_pkg::S_IDLE && !to_key && !to_mode |=>
        state == fguard_pkg::S_IDLE && !$rose(error_flag))
        else $error("unrelated idle store disturbed the tracker");

    a_permit_rule: assert property (@(posedge MCLK) disable iff (SYS_RST)
        FLASH_WR_PERMIT |-> $past(pin_level) && !$past(inhibit))
        else $error("write permit given without pin and inhibit conditions");

    a_onboard_ignores: assert property (@(posedge MCLK) disable iff (SYS_RST)
        onboard && $past(onboard) |-> !FW_CALL_EN && !FW_ROM_FETCH)
        else $error("mode select acted in on-board mode");

    a_status_reset: assert property (@(posedge MCLK)
        $fell(SYS_RST) |-> !error_flag)
        else $error("protect status not cleared by reset");

    a_mode_reset: assert property (@(posedge MCLK)
        $fell(SYS_RST) |-> inhibit && mode == fguard_pkg::MODE_NORMAL)
        else $error("mode register not at its reset value");

    a_key_needed: assert property (@(posedge MCLK) disable iff (SYS_RST)
        store && to_mode && state == fguard_pkg::S_IDLE |=>
        error_flag && $stable(inhibit) && $stable(mode))
        else $error("mode register store without a key was not refused");

    a_clear_on_zero: assert property (@(posedge MCLK) disable iff (SYS_RST)
        store && to_status && !SFR_WDATA[fguard_pkg::ERROR_BIT] && !violation |=> !error_flag)
        else $error("writing zero did not clear the error flag");

    a_back_to_idle: assert property (@(posedge MCLK) disable iff (SYS_RST)
        store && (violation || update) |=> state == fguard_pkg::S_IDLE)
        else $error("tracker did not return to idle");

    a_prohibited_kept: assert property (@(posedge MCLK) disable iff (SYS_RST)
        update && SFR_WDATA[1:0] == fguard_pkg::MODE_PROHIBITED |=> $stable(mode))
        else $error("prohibited mode was accepted");

    a_fetch_needs_priv: assert property (@(posedge MCLK) disable iff (SYS_RST)
        update && SFR_WDATA[1:0] == fguard_pkg::MODE_FW_FETCH && !FW_PRIV |=> $stable(mode))
        else $error("firmware fetch mode set without privilege");

    a_read_view: assert property (@(posedge MCLK) disable iff (SYS_RST)
        CLK_EN && SFR_RD && SFR_ADDR == fguard_pkg::MODE_CTRL_ADDR |=>
        SFR_RDATA[7:4] == 4'h0 && SFR_RDATA[fguard_pkg::PIN_BIT] == $past(pin_level))
        else $error("mode register read-back layout wrong");

    a_swap_frozen: assert property (@(posedge MCLK) disable iff (SYS_RST)
        strap_taken && $past(strap_taken) |-> $stable(BOOT_SWAPPED))
        else $error("boot swap changed after start");

    a_addr_from_cpu: assert property (@(posedge MCLK) disable iff (SYS_RST)
        CLK_EN && !mode_eff[1] && !swap |=> FLASH_ADDR == $past(CPU_ADDR))
        else $error("flash address not taken from the CPU");

    a_addr_from_fw: assert property (@(posedge MCLK) disable iff (SYS_RST)
        CLK_EN && mode_eff[1] && !swap |=> FLASH_ADDR == $past(FW_ADDR))
        else $error("flash address not taken from firmware");

    a_permit_given: assert property (@(posedge MCLK) disable iff (SYS_RST)
        CLK_EN && !inhibit && pin_level |=> FLASH_WR_PERMIT)
        else $error("write permit withheld with pin and inhibit conditions met");
endmodule : flash_mode_write_guard

/* test/cpu_store_model.sv */
// Behavioural CPU that issues single-byte peripheral stores and reads to the guard.
// Assumes the bench calls its tasks from one process and that reads answer one cycle later.
`timescale 1ns/1ps
module cpu_store_model (
    // Clock
    input wire logic clk,
    // Peripheral store and read port
    output logic wr,
    output logic rd,
    output logic [15:0] addr,
    output logic [7:0] wdata
);
    logic [7:0] exp_q[$];

    initial begin
        wr = 1'b0;
        rd = 1'b0;
        addr = 16'h0000;
        wdata = 8'h00;
    end

    // Released lines show the inverse of their last value, so stale data never looks valid.
    task automatic store(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(posedge clk);
        wr <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask : store

    // The expected answer is queued at the edge that takes the read.
    task automatic load(input logic [15:0] a, input logic [7:0] e);
        @(negedge clk);
        rd = 1'b1;
        addr = a;
        @(posedge clk);
        exp_q.push_back(e);
        rd <= 1'b0;
        addr <= ~a;
    endtask : load

    task automatic unlock(input logic [7:0] v);
        store(fguard_pkg::UNLOCK_KEY_ADDR, fguard_pkg::UNLOCK_KEY_VALUE);
        store(fguard_pkg::MODE_CTRL_ADDR, v);
        store(fguard_pkg::MODE_CTRL_ADDR, ~v);
        store(fguard_pkg::MODE_CTRL_ADDR, v);
    endtask : unlock
endmodule : cpu_store_model

/* test/flash_mode_write_guard_tb_top.sv */
// Self-checking bench for the flash mode write guard.
// Assumes the CPU model drives the store port; reads are checked by a watcher process.
`timescale 1ns/1ps
module flash_mode_write_guard_tb_top;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    logic fw_priv = 1'b0;
    logic pin = 1'b1;
    logic onboard = 1'b0;
    logic boot_flag = 1'b0;
    logic swp_exp = 1'b0;
    logic [15:0] cpu_addr = 16'h0000;
    logic [15:0] fw_addr = 16'h0000;
    logic sfr_wr, sfr_rd, flash_wr_permit, fw_call_en, fw_rom_fetch, boot_swapped, prot_error;
    logic [15:0] sfr_addr, flash_addr;
    logic [7:0] sfr_wdata, sfr_rdata, v;
    logic [7:0] mode_exp = 8'h08;
    int n_fail = 0;
    int n_compared = 0;
    int seed = 76744;

    always #5 mclk = ~mclk;

    cpu_store_model u_cpu (.clk(mclk), .wr(sfr_wr), .rd(sfr_rd), .addr(sfr_addr), .wdata(sfr_wdata));

    flash_mode_write_guard u_dut (
        .MCLK(mclk), .SYS_RST(sys_rst), .CLK_EN(clk_en),
        .SFR_WR(sfr_wr), .SFR_RD(sfr_rd), .SFR_ADDR(sfr_addr), .SFR_WDATA(sfr_wdata), .SFR_RDATA(sfr_rdata),
        .FW_PRIV(fw_priv), .FLASH_MODE_PIN(pin), .ONBOARD_MODE(onboard), .BOOT_FLAG(boot_flag),
        .CPU_ADDR(cpu_addr), .FW_ADDR(fw_addr), .FLASH_ADDR(flash_addr),
        .FLASH_WR_PERMIT(flash_wr_permit), .FW_CALL_EN(fw_call_en), .FW_ROM_FETCH(fw_rom_fetch),
        .BOOT_SWAPPED(boot_swapped), .PROT_ERROR(prot_error)
    );

    task automatic results();
        if (n_fail == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Read answers are compared one nanosecond after the edge that took the read.
    always @(posedge mclk) begin : rd_watch
        logic taken;
        taken = sfr_rd && clk_en;
        #1;
        if (taken && u_cpu.exp_q.size() > 0) begin
            check({8'h00, sfr_rdata}, {8'h00, u_cpu.exp_q.pop_front()});
        end
    end

    initial begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        results();
    end

    task automatic settle();
        repeat (3) @(negedge mclk);
    endtask : settle

    task automatic do_reset();
        @(negedge mclk);
        sys_rst = 1'b1;
        repeat (12) @(negedge mclk);
        sys_rst = 1'b0;
        mode_exp = 8'h08;
        repeat (4) @(negedge mclk);
    endtask : do_reset

    task automatic rd_mode();
        u_cpu.load(fguard_pkg::MODE_CTRL_ADDR, mode_exp | {5'h00, pin, 2'h0});
    endtask : rd_mode

    task automatic chk_out(input logic err);
        logic [1:0] m;
        logic [15:0] a;
        @(negedge mclk);
        m = onboard ? 2'h0 : mode_exp[1:0];
        a = m[1] ? fw_addr : cpu_addr;
        if (swp_exp && a < 16'h2000) begin
            a[12] = ~a[12];
        end
        check({12'h000, flash_wr_permit, fw_call_en, fw_rom_fetch, prot_error},
              {12'h000, !mode_exp[3] && pin, m == 2'h1, m == 2'h3, err});
        check(flash_addr, a);
        check({15'h0000, boot_swapped}, {15'h0000, swp_exp});
    endtask : chk_out

    // Mode 10, and 11 without privilege, keep the old mode bits; inhibit still follows.
    task automatic update(input logic [7:0] nv, input logic priv);
        @(negedge mclk);
        fw_priv = priv;
        u_cpu.unlock(nv);
        if (nv[1:0] != 2'h2 && (nv[1:0] != 2'h3 || priv)) begin
            mode_exp = {4'h0, nv[3], 1'b0, nv[1:0]};
        end else begin
            mode_exp[3] = nv[3];
        end
    endtask : update

    task automatic faulted(input int k);
        if (k != 0) begin
            u_cpu.store(fguard_pkg::UNLOCK_KEY_ADDR, fguard_pkg::UNLOCK_KEY_VALUE);
            u_cpu.store(fguard_pkg::MODE_CTRL_ADDR, 8'h08);
        end
        case (k)
            0: u_cpu.store(fguard_pkg::UNLOCK_KEY_ADDR, 8'h5a);
            1: u_cpu.store(16'hff00, 8'hf7);
            2: u_cpu.store(fguard_pkg::MODE_CTRL_ADDR, 8'h08);
            3: begin
                u_cpu.store(fguard_pkg::MODE_CTRL_ADDR, 8'hf7);
                u_cpu.store(fguard_pkg::MODE_CTRL_ADDR, 8'h09);
            end
            default: u_cpu.store(fguard_pkg::UNLOCK_KEY_ADDR, fguard_pkg::UNLOCK_KEY_VALUE);
        endcase
    endtask : faulted

    initial begin
        do_reset();
        u_cpu.load(fguard_pkg::PROT_STATUS_ADDR, 8'h00);
        rd_mode();
        chk_out(1'b0);
        // Without a key since reset the sequence must not land.
        u_cpu.store(fguard_pkg::MODE_CTRL_ADDR, 8'h01);
        u_cpu.store(fguard_pkg::MODE_CTRL_ADDR, 8'hfe);
        u_cpu.store(fguard_pkg::MODE_CTRL_ADDR, 8'h01);
        settle();
        rd_mode();
        chk_out(1'b1);
        u_cpu.store(fguard_pkg::PROT_STATUS_ADDR, 8'h00);
        u_cpu.load(fguard_pkg::PROT_STATUS_ADDR, 8'h00);
        u_cpu.store(16'hff00, 8'h5a);
        update(8'h01, 1'b0);
        settle();
        u_cpu.load(fguard_pkg::PROT_STATUS_ADDR, 8'h00);
        rd_mode();
        chk_out(1'b0);
        u_cpu.store(fguard_pkg::MODE_CTRL_ADDR, 8'h00);
        settle();
        rd_mode();
        for (int k = 0; k < 5; k++) begin
            u_cpu.store(fguard_pkg::PROT_STATUS_ADDR, 8'h00);
            faulted(k);
            settle();
            u_cpu.load(fguard_pkg::PROT_STATUS_ADDR, 8'h01);
            rd_mode();
        end
        u_cpu.store(fguard_pkg::PROT_STATUS_ADDR, 8'h01);
        u_cpu.load(fguard_pkg::PROT_STATUS_ADDR, 8'h01);
        u_cpu.store(fguard_pkg::PROT_STATUS_ADDR, 8'h00);
        u_cpu.load(fguard_pkg::PROT_STATUS_ADDR, 8'h00);
        u_cpu.load(16'hff10, 8'h00);
        // A store while the clock enable is low must not be taken.
        @(negedge mclk);
        clk_en = 1'b0;
        u_cpu.store(fguard_pkg::MODE_CTRL_ADDR, 8'h00);
        @(negedge mclk);
        clk_en = 1'b1;
        u_cpu.load(fguard_pkg::PROT_STATUS_ADDR, 8'h00);
        update(8'h02, 1'b0);
        update(8'h03, 1'b0);
        settle();
        rd_mode();
        update(8'h03, 1'b1);
        settle();
        chk_out(1'b0);
        update(8'h08, 1'b0);
        for (int i = 0; i < 8; i++) begin
            @(negedge mclk);
            cpu_addr = 16'($random(seed));
            fw_addr = 16'($random(seed));
            v = 8'($random(seed)) & 8'h0b;
            update(v, 1'($random(seed)));
            settle();
            chk_out(1'b0);
            rd_mode();
        end
        update(8'h00, 1'b0);
        @(negedge mclk);
        pin = 1'b0;
        repeat (5) @(negedge mclk);
        rd_mode();
        chk_out(1'b0);
        boot_flag = 1'b1;
        cpu_addr = 16'h0084;
        repeat (5) @(negedge mclk);
        chk_out(1'b0);
        onboard = 1'b1;
        pin = 1'b1;
        do_reset();
        swp_exp = 1'b1;
        for (int j = 0; j < 4; j++) begin
            cpu_addr = (j == 0) ? 16'h0084 : (j == 1) ? 16'h0085 : (j == 2) ? 16'h1085 : 16'h2000;
            settle();
            chk_out(1'b0);
        end
        update(8'h01, 1'b0);
        settle();
        chk_out(1'b0);
        results();
    end
endmodule : flash_mode_write_guard_tb_top
